//--- hw/usr_baud.sv
`timescale 1ns/1ps
`default_nettype none
module usr_baud (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [usr_pkg::BAUD_W-1:0] divider,
  input wire logic double_speed,
  input wire logic sync_mode,
  input wire logic sync_master,
  input wire logic clock_polarity,
  input wire logic run,
  input wire logic xck_in,
  output logic xck_out,
  usr_tick_if.gen tk
);
  import usr_pkg::*;

  logic [BAUD_W-1:0] div_cnt;
  logic [3:0] os_cnt;
  logic xs1, xs2, lvl_d;
  logic div_hit, lvl, rise, fall;
  logic [4:0] os_per_bit;

  assign div_hit = run && (div_cnt == divider);
  assign os_per_bit = double_speed ? OS_DOUBLE : OS_NORMAL;

  // Baud divider, period divider+1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
    end else if (!run || div_hit) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // Oversample count to one bit time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      os_cnt <= '0;
    end else if (!run || sync_mode) begin
      os_cnt <= '0;
    end else if (div_hit) begin
      os_cnt <= (os_cnt == 4'(os_per_bit - 5'h1)) ? 4'h0 : os_cnt + 1'b1;
    end
  end

  // Master transfer clock, toggles per divider period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xck_out <= 1'b0;
    end else if (!run || !sync_mode || !sync_master) begin
      xck_out <= 1'b0;
    end else if (div_hit) begin
      xck_out <= ~xck_out;
    end
  end

  // External clock synchroniser and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xs1 <= 1'b0;
      xs2 <= 1'b0;
      lvl_d <= 1'b0;
    end else begin
      xs1 <= xck_in;
      xs2 <= xs1;
      lvl_d <= lvl;
    end
  end

  // Edge selection by polarity
  assign lvl = sync_master ? xck_out : xs2;
  assign rise = lvl && !lvl_d;
  assign fall = !lvl && lvl_d;
  assign tk.os_tick = div_hit && !sync_mode;
  assign tk.bit_tick = sync_mode ? (clock_polarity ? fall : rise)
                     : (div_hit && os_cnt == 4'(os_per_bit - 5'h1));
  assign tk.samp_tick = run && sync_mode && (clock_polarity ? rise : fall);
endmodule
`default_nettype wire

//--- hw/usr_serial_top.sv
// Summary of operation
// R1: Transmit enable makes the block drive the serial output pin.
// R2: Synchronous mode drives and uses the transfer clock pin for transmit; the block drives it only with sync_master set, a slave only reads it.
// R3: Data write loads buffer; moved to shifter when idle or after last stop.
// R4: Loaded shifter sends one frame timed by divider, double speed or clock.
// R5: Unused high data bits are ignored for short characters.
// R6: Nine-bit mode sends the ninth bit latched from control at data write.
// R7: Buffer-empty reads one when empty, zero while data waits.
// R8: Writing the data register clears buffer-empty.
// R9: Buffer-empty request stays raised while flag set and enabled.
// R10: Software writes zero to the buffer-empty status position.
// R11: Transmit-complete sets when frame done and buffer empty.
// R12: Transmit-complete clears on interrupt service or writing one.
// R13: Transmit-complete request rises when the flag becomes set if enabled.
// R14: Parity enable inserts parity after data, before first stop.
// R15: Disabled transmitter finishes shifter and buffer before releasing pin.
// R16: Receive enable makes the block take the serial input pin.
// R17: Synchronous receive is timed by the transfer clock.
// R18: Receive starts on valid start bit; samples to first stop bit.
// R19: First stop bit moves the received word into the receive buffer.
// R20: Unused high bits of received data read as zero.
// R21: Software sets rate, mode and format before transmitting.
// R22: Frame is start, data LSB first, optional parity, one or two stops.
// R23: Parity is xor of data bits, inverted for odd.
// R24: Receive-complete reads one while unread data sits in buffer.
// R25: Polarity zero changes data on rising, samples on falling edge.
// R26: Transmit line idles high between and without frames.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module usr_serial_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  output logic serial_in_claimed,
  output logic serial_out_pin,
  output logic serial_out_oe_n,
  input wire logic transfer_clock_pin_in,
  output logic transfer_clock_pin_out,
  output logic transfer_clock_pin_oe_n,
  output logic tx_buffer_empty_irq,
  output logic tx_complete_irq,
  input wire logic tx_complete_irq_ack
);
  import usr_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} usr_rx_e;

  usr_tick_if tk ();

  logic transmit_enable_bit, receive_enable_bit, tx_ninth_bit;
  logic tx_buffer_empty_irq_enable, tx_complete_irq_enable;
  logic double_speed_bit, parity_enable_bit, parity_odd_select;
  logic two_stop, sync_mode, clock_polarity_bit, sync_master;
  logic [2:0] char_size_field;
  logic [BAUD_W-1:0] baud_divider_value;
  logic [8:0] tx_buf;
  logic tx_buf_full, tx_busy, tx_complete_flag;
  logic [FRAME_W-1:0] tx_shift, next_frame;
  logic [3:0] tx_cnt, frame_len, n_data;
  logic tx_last, tx_move, tx_done, tx_load_ok;
  usr_rx_e rx_state;
  logic [3:0] rx_os, rx_cnt, rx_total;
  logic [RXSH_W-1:0] rx_shift, rx_word;
  logic [8:0] rx_buf, rx_masked;
  logic rx_complete_flag, rx_strobe, rx_done, rx_take;
  logic [4:0] os_per_bit;
  logic acc, wr_en, rd_en, addr_ok;
  logic [31:0] rd_mux;

  // APB decode, single-cycle access phase
  assign acc = psel && penable;
  assign wr_en = acc && pwrite && addr_ok;
  assign rd_en = acc && !pwrite && addr_ok;
  assign addr_ok = (paddr == OFF_DATA) || (paddr == OFF_STATUS) ||
                   (paddr == OFF_CTRL) || (paddr == OFF_FMT) ||
                   (paddr == OFF_BAUD);
  assign pready = 1'b1;
  assign pslverr = acc && !addr_ok;
  assign rx_take = rd_en && (paddr == OFF_DATA);

  // Character size code to data bit count
  always_comb begin
    unique case (char_size_field)
      3'h0: n_data = 4'h5;
      3'h1: n_data = 4'h6;
      3'h2: n_data = 4'h7;
      CSZ_NINE: n_data = 4'h9;
      default: n_data = 4'h8;
    endcase
  end

  // Frame builder from the buffer
  always_comb begin
    logic par;
    par = parity_odd_select; // R23
    next_frame = '1;
    next_frame[0] = 1'b0; // R22
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n_data) begin
        next_frame[i + 1] = tx_buf[i]; // R5
        par = par ^ tx_buf[i]; // R23
      end
    end
    if (parity_enable_bit) begin
      next_frame[4'(n_data + 4'h1)] = par; // R14
    end
    frame_len = 4'(4'h2 + n_data + {3'h0, parity_enable_bit} + {3'h0, two_stop});
  end

  // Control and configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_enable_bit <= 1'b0;
      receive_enable_bit <= 1'b0;
      tx_ninth_bit <= 1'b0;
      tx_buffer_empty_irq_enable <= 1'b0;
      tx_complete_irq_enable <= 1'b0;
      double_speed_bit <= 1'b0;
      char_size_field <= CSZ_RST;
      parity_enable_bit <= 1'b0;
      parity_odd_select <= 1'b0;
      two_stop <= 1'b0;
      sync_mode <= 1'b0;
      clock_polarity_bit <= 1'b0;
      sync_master <= 1'b0;
      baud_divider_value <= BAUD_RST;
    end else if (wr_en) begin
      if (paddr == OFF_CTRL) begin
        transmit_enable_bit <= pwdata[CT_TRANSMIT_ENABLE_BIT];
        receive_enable_bit <= pwdata[CT_RXEN];
        tx_ninth_bit <= pwdata[CT_TX_NINTH_BIT];
        tx_buffer_empty_irq_enable <= pwdata[CT_UDRIE];
        tx_complete_irq_enable <= pwdata[CT_TXCIE];
      end
      if (paddr == OFF_STATUS) begin
        double_speed_bit <= pwdata[ST_U2X];
      end
      if (paddr == OFF_FMT) begin
        char_size_field <= pwdata[FM_CSZ +: 3];
        parity_enable_bit <= pwdata[FM_PEN];
        parity_odd_select <= pwdata[FM_PODD];
        two_stop <= pwdata[FM_STOP2];
        sync_mode <= pwdata[FM_SYNC];
        clock_polarity_bit <= pwdata[FM_CPOL];
        sync_master <= pwdata[FM_MASTER];
      end
      if (paddr == OFF_BAUD) begin
        baud_divider_value <= pwdata[BAUD_W-1:0];
      end
    end
  end

  // Read mux, captured in the setup phase
  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr)
      OFF_DATA: rd_mux[8:0] = {1'b0, rx_buf[7:0]};
      OFF_STATUS: begin
        rd_mux[ST_RXC] = rx_complete_flag; // R24
        rd_mux[ST_UDRE] = !tx_buf_full; // R7
        rd_mux[ST_TXC] = tx_complete_flag;
        rd_mux[ST_U2X] = double_speed_bit;
      end
      OFF_CTRL: begin
        rd_mux[CT_TRANSMIT_ENABLE_BIT] = transmit_enable_bit;
        rd_mux[CT_RXEN] = receive_enable_bit;
        rd_mux[CT_TX_NINTH_BIT] = tx_ninth_bit;
        rd_mux[CT_RXB8] = rx_buf[8];
        rd_mux[CT_UDRIE] = tx_buffer_empty_irq_enable;
        rd_mux[CT_TXCIE] = tx_complete_irq_enable;
      end
      OFF_FMT: rd_mux[8:0] = {sync_master, clock_polarity_bit, sync_mode, two_stop,
                              parity_odd_select, parity_enable_bit, char_size_field};
      OFF_BAUD: rd_mux[BAUD_W-1:0] = baud_divider_value;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Bit timing and transfer clock
  usr_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .divider(baud_divider_value),
    .double_speed(double_speed_bit),
    .sync_mode(sync_mode),
    .sync_master(sync_master),
    .clock_polarity(clock_polarity_bit),
    .run(transmit_enable_bit || receive_enable_bit || tx_busy || tx_buf_full),
    .xck_in(transfer_clock_pin_in),
    .xck_out(transfer_clock_pin_out),
    .tk(tk.gen)
  );

  // Master drives transfer clock while enabled
  assign transfer_clock_pin_oe_n = !(sync_mode && sync_master &&
    (transmit_enable_bit || receive_enable_bit || tx_busy || tx_buf_full)); // R2 R15

  // Transmit buffer; a write wins over the hand-off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_full <= 1'b0;
      tx_buf <= 9'h000;
    end else if (wr_en && paddr == OFF_DATA && transmit_enable_bit) begin
      tx_buf_full <= 1'b1; // R8
      tx_buf <= {tx_ninth_bit, pwdata[7:0]}; // R6
    end else if (tx_move) begin
      tx_buf_full <= 1'b0; // R7
    end
  end

  // Shifter hand-off points
  assign tx_last = tx_busy && tk.bit_tick && (tx_cnt == 4'(frame_len - 4'h1));
  // Idle load waits for a bit tick so the start bit is full length
  assign tx_load_ok = !tx_busy && tk.bit_tick; // R4
  assign tx_move = tx_buf_full && (tx_load_ok || tx_last); // R3
  assign tx_done = tx_last && !tx_buf_full; // R11

  // Transmit shifter, LSB first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy <= 1'b0;
      tx_shift <= '1;
      tx_cnt <= 4'h0;
    end else if (tx_move) begin
      tx_busy <= 1'b1; // R4
      tx_shift <= next_frame;
      tx_cnt <= 4'h0;
    end else if (tx_done) begin
      tx_busy <= 1'b0;
      tx_shift <= '1; // R26
    end else if (tx_busy && tk.bit_tick) begin
      tx_shift <= {1'b1, tx_shift[FRAME_W-1:1]}; // R4
      tx_cnt <= tx_cnt + 1'b1;
    end
  end

  assign serial_out_pin = tx_shift[0]; // R26
  assign serial_out_oe_n = !(transmit_enable_bit || tx_busy || tx_buf_full); // R1 R15

  // Transmit-complete flag; setting wins over clearing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_complete_flag <= 1'b0;
    end else if (tx_done) begin
      tx_complete_flag <= 1'b1; // R11
    end else if (tx_complete_irq_ack ||
                 (wr_en && paddr == OFF_STATUS && pwdata[ST_TXC])) begin
      tx_complete_flag <= 1'b0; // R12
    end
  end

  // Interrupt requests
  assign tx_buffer_empty_irq = tx_buffer_empty_irq_enable && !tx_buf_full; // R9
  assign tx_complete_irq = tx_complete_irq_enable && tx_complete_flag; // R13

  // Receiver sample strobe
  assign os_per_bit = double_speed_bit ? OS_DOUBLE : OS_NORMAL;
  assign rx_strobe = sync_mode ? tk.samp_tick // R17 R25
                   : (tk.os_tick && rx_os == 4'(os_per_bit - 5'h1));
  assign rx_total = 4'(n_data + {3'h0, parity_enable_bit} + 4'h1);
  assign rx_done = (rx_state == RX_BITS) && rx_strobe &&
                   (rx_cnt == 4'(rx_total - 4'h1));
  assign serial_in_claimed = receive_enable_bit; // R16

  // Receive sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_IDLE;
      rx_os <= 4'h0;
      rx_cnt <= 4'h0;
      rx_shift <= '0;
    end else if (!receive_enable_bit) begin
      rx_state <= RX_IDLE;
    end else begin
      unique case (rx_state)
        RX_IDLE: begin
          rx_os <= 4'h0;
          rx_cnt <= 4'h0;
          if (sync_mode && tk.samp_tick && !serial_in_pin) begin
            rx_state <= RX_BITS; // R18
          end else if (!sync_mode && tk.os_tick && !serial_in_pin) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (tk.os_tick) begin
            if (rx_os == 4'(os_per_bit[4:1] - 4'h1)) begin
              rx_os <= 4'h0;
              rx_state <= serial_in_pin ? RX_IDLE : RX_BITS; // R18
            end else begin
              rx_os <= rx_os + 1'b1;
            end
          end
        end
        RX_BITS: begin
          if (tk.os_tick) begin
            rx_os <= (rx_os == 4'(os_per_bit - 5'h1)) ? 4'h0 : rx_os + 1'b1;
          end
          if (rx_strobe) begin
            rx_shift <= {serial_in_pin, rx_shift[RXSH_W-1:1]}; // R18
            rx_cnt <= rx_cnt + 1'b1;
            if (rx_done) begin
              rx_state <= RX_IDLE; // R18
            end
          end
        end
      endcase
    end
  end

  // Align received word and mask unused bits
  always_comb begin
    rx_word = {serial_in_pin, rx_shift[RXSH_W-1:1]} >> (4'(RXSH_W) - rx_total);
    for (int i = 0; i < 9; i++) begin
      rx_masked[i] = (4'(i) < n_data) && rx_word[i]; // R20
    end
  end

  // Receive buffer; disable flushes, arrival beats a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_complete_flag <= 1'b0;
      rx_buf <= 9'h000;
    end else if (!receive_enable_bit) begin
      rx_complete_flag <= 1'b0;
    end else if (rx_done) begin
      rx_complete_flag <= 1'b1; // R24
      rx_buf <= rx_masked; // R19
    end else if (rx_take) begin
      rx_complete_flag <= 1'b0; // R24
    end
  end
endmodule
`default_nettype wire

//--- shared/usr_pkg.sv
package usr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_FMT = 8'h0c;
  localparam logic [7:0] OFF_BAUD = 8'h10;
  // Status register bits
  localparam int unsigned ST_RXC = 0;
  localparam int unsigned ST_UDRE = 1;
  localparam int unsigned ST_TXC = 2;
  localparam int unsigned ST_U2X = 3;
  // Control register bits
  localparam int unsigned CT_TRANSMIT_ENABLE_BIT = 0;
  localparam int unsigned CT_RXEN = 1;
  localparam int unsigned CT_TX_NINTH_BIT = 2;
  localparam int unsigned CT_RXB8 = 3;
  localparam int unsigned CT_UDRIE = 4;
  localparam int unsigned CT_TXCIE = 5;
  // Format register fields
  localparam int unsigned FM_CSZ = 0;
  localparam int unsigned FM_PEN = 3;
  localparam int unsigned FM_PODD = 4;
  localparam int unsigned FM_STOP2 = 5;
  localparam int unsigned FM_SYNC = 6;
  localparam int unsigned FM_CPOL = 7;
  localparam int unsigned FM_MASTER = 8;
  // Widths, codes and reset values
  localparam int unsigned BAUD_W = 12;
  localparam logic [2:0] CSZ_NINE = 3'h7;
  localparam logic [2:0] CSZ_RST = 3'h3;
  localparam logic [11:0] BAUD_RST = 12'h000;
  localparam logic [4:0] OS_NORMAL = 5'h10;
  localparam logic [4:0] OS_DOUBLE = 5'h08;
  localparam int unsigned FRAME_W = 13;
  localparam int unsigned RXSH_W = 11;
endpackage

//--- shared/usr_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface usr_tick_if;
  logic os_tick;
  logic bit_tick;
  logic samp_tick;
  modport gen (output os_tick, output bit_tick, output samp_tick);
  modport use_side (input os_tick, input bit_tick, input samp_tick);
endinterface
`default_nettype wire

//--- tb/usr_remote.sv
`timescale 1ns/1ps
`default_nettype none
module usr_remote #(
  parameter int BITC = 32
) (
  input wire logic pclk,
  input wire logic line_in,
  output logic line_out,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  input wire logic stop2,
  input wire logic xck
);
  logic [11:0] got_q[$];
  logic [11:0] w;
  int i;
  initial line_out = 1'b1;
  logic [9:0] sw;
  logic [9:0] sync_q[$];
  int sc = 0;
  // Synchronous capture: ten bits from the start bit, at falling clock edges
  always @(negedge xck) begin
    if (sc > 0 || line_in === 1'b0) begin
      sw[sc] = line_in;
      sc = (sc + 1) % 10;
      if (sc == 0)
        sync_q.push_back(sw);
    end
  end
  // Capture: start, data LSB first, parity at bit 9, stops at 10 and 11
  always begin
    @(posedge pclk iff line_in === 1'b0);
    repeat (BITC / 2) @(posedge pclk);
    w = 12'h800;
    for (i = 0; i < 11; i++) begin
      if (i < nbits || (i == 9 && par_en) || i == 10) begin
        repeat (BITC) @(posedge pclk);
        w[i] = line_in;
      end
    end
    if (stop2) begin
      repeat (BITC) @(posedge pclk);
      w[11] = line_in;
    end
    got_q.push_back(w);
  end
  // Send one frame toward the block, line left high
  task automatic send(input logic [8:0] d, input logic p);
    int k;
    line_out <= 1'b0;
    repeat (BITC) @(posedge pclk);
    for (k = 0; k < nbits; k++) begin
      line_out <= d[k];
      repeat (BITC) @(posedge pclk);
    end
    if (par_en) begin
      line_out <= p;
      repeat (BITC) @(posedge pclk);
    end
    line_out <= 1'b1;
    repeat (2 * BITC) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

//--- tb/usr_serial_props.sv
`timescale 1ns/1ps
`default_nettype none
module usr_serial_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_in_pin,
  input wire logic serial_in_claimed,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe_n,
  input wire logic transfer_clock_pin_in,
  input wire logic transfer_clock_pin_out,
  input wire logic transfer_clock_pin_oe_n,
  input wire logic tx_buffer_empty_irq,
  input wire logic tx_complete_irq,
  input wire logic tx_complete_irq_ack
);
  import usr_pkg::*;
  logic [31:0] ctrl_q;
  logic wr;
  // Bus write strobe at the access edge
  assign wr = psel && penable && pwrite;
  // Shadow of the control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 32'h0;
    end else if (wr && paddr == OFF_CTRL) begin
      ctrl_q <= pwdata;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  transmit_enable_bit_drives_a: assert property (ctrl_q[CT_TRANSMIT_ENABLE_BIT] |-> !serial_out_oe_n)
    else $error("tx pin not driven while enabled");
  idle_high_a: assert property (serial_out_oe_n |-> serial_out_pin)
    else $error("released tx line not high");
  hold_pin_a: assert property (!serial_out_pin |-> !serial_out_oe_n)
    else $error("tx pin released mid frame");
  rx_claim_a: assert property (serial_in_claimed == ctrl_q[CT_RXEN])
    else $error("rx pin claim wrong");
  empty_irq_en_a: assert property (tx_buffer_empty_irq |-> ctrl_q[CT_UDRIE])
    else $error("empty request while disabled");
  empty_idle_a: assert property (ctrl_q[CT_UDRIE] && serial_out_oe_n |-> tx_buffer_empty_irq)
    else $error("idle but empty request low");
  wr_clears_a: assert property (wr && paddr == OFF_DATA && ctrl_q[CT_TRANSMIT_ENABLE_BIT] |=> !tx_buffer_empty_irq)
    else $error("data write left empty request");
  txc_irq_en_a: assert property (tx_complete_irq |-> ctrl_q[CT_TXCIE])
    else $error("complete request while disabled");
  ack_clears_a: assert property (tx_complete_irq_ack || (wr && paddr == OFF_STATUS && pwdata[ST_TXC])
    |=> !tx_complete_irq)
    else $error("complete flag not cleared");
  txc_end_a: assert property ($rose(tx_complete_irq) && ctrl_q[CT_UDRIE] |-> tx_buffer_empty_irq && serial_out_pin)
    else $error("complete set with data pending");
  cover property ($rose(tx_complete_irq));
  cover property ($fell(tx_buffer_empty_irq));
  cover property ($rose(serial_out_oe_n));
endmodule
`default_nettype wire

//--- tb/usr_serial_test.sv
`timescale 1ns/1ps
`default_nettype none
module usr_serial_test;
  import usr_pkg::*;
  localparam int BITC = 32;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ack = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_pin, claimed, tx_pin, tx_oe_n, xck_o, xck_oe_n, empty_irq, done_irq, line;
  logic [3:0] nb = 4'h8;
  logic pe = 1'b0;
  logic s2 = 1'b0;
  logic [31:0] seed = 32'h3b;
  logic [31:0] r;
  logic e;
  logic [11:0] exp_q[$];
  int bad_count = 0;
  int n_tests = 0;
  logic [2:0] csz_t[4] = '{3'h0, 3'h3, 3'h7, 3'h2};
  logic [2:0] opt_t[4] = '{3'h0, 3'h1, 3'h7, 3'h4};
  logic [31:0] rst_t[4] = '{32'h2, 32'h0, 32'h3, 32'h0};
  // Released line is pulled to idle high
  assign line = tx_oe_n ? 1'b1 : tx_pin;
  initial begin
    forever #25 pclk = ~pclk;
  end
  usr_serial_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(rx_pin), .serial_in_claimed(claimed), .serial_out_pin(tx_pin), .serial_out_oe_n(tx_oe_n),
    .transfer_clock_pin_in(1'b0), .transfer_clock_pin_out(xck_o), .transfer_clock_pin_oe_n(xck_oe_n),
    .tx_buffer_empty_irq(empty_irq), .tx_complete_irq(done_irq), .tx_complete_irq_ack(ack));
  usr_remote #(.BITC(BITC)) remote (.pclk(pclk), .line_in(line), .line_out(rx_pin), .nbits(nb),
    .par_en(pe), .stop2(s2), .xck(xck_o));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected frame: stops, parity, data masked to size
  function automatic logic [11:0] frame(logic [8:0] d, int n, logic p, logic o);
    logic [8:0] m;
    m = d & 9'((1 << n) - 1);
    return {2'b11, p & (^m ^ o), m};
  endfunction
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_f(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: frame %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
    output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      $display("MISMATCH at %0t: bus wait ran out", $time);
      conclude();
    end
  endtask
  task automatic poll(input int b, input logic v, input int lim);
    int k;
    k = 0;
    do begin
      apb(OFF_STATUS, 1'b0, 32'h0, r, e);
      k++;
    end while (r[b] !== v && k < lim);
    if (r[b] !== v) begin
      bad_count++;
      $display("MISMATCH at %0t: wait ran out", $time);
      conclude();
    end
  endtask
  initial begin
    int i;
    logic [31:0] d, d2, ctl;
    logic [11:0] f;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      apb(OFF_STATUS + 8'(4 * i), 1'b0, 32'h0, r, e);
      cmp(r, rst_t[i]);
    end
    apb(8'h14, 1'b1, rnd(), r, e);
    apb(8'h14, 1'b0, 32'h0, r, e);
    cmp({r[30:0], e}, 32'h1);
    apb(OFF_BAUD, 1'b1, 32'h1, r, e);
    for (i = 0; i < 4; i++) begin
      nb <= (csz_t[i] == CSZ_NINE) ? 4'h9 : 4'h5 + 4'(csz_t[i]);
      {s2, pe} <= {opt_t[i][2], opt_t[i][0]};
      apb(OFF_FMT, 1'b1, {26'h0, opt_t[i], csz_t[i]}, r, e);
      d = rnd();
      d2 = rnd();
      ctl = 32'h33 | {29'h0, d[8], 2'b00};
      apb(OFF_CTRL, 1'b1, ctl, r, e);
      apb(OFF_DATA, 1'b1, d, r, e);
      exp_q.push_back(frame(d[8:0], int'(nb), opt_t[i][0], opt_t[i][1]));
      poll(ST_UDRE, 1'b1, 50);
      apb(OFF_CTRL, 1'b1, 32'h33 | {29'h0, d2[8], 2'b00}, r, e);
      apb(OFF_DATA, 1'b1, d2, r, e);
      exp_q.push_back(frame(d2[8:0], int'(nb), opt_t[i][0], opt_t[i][1]));
      apb(OFF_STATUS, 1'b0, 32'h0, r, e);
      cmp(r & 32'h6, 32'h0);
      apb(OFF_CTRL, 1'b1, 32'h32, r, e);
      poll(ST_TXC, 1'b1, 600);
      @(posedge pclk);
      cmp({29'h0, done_irq, empty_irq, tx_oe_n}, 32'h7);
      cmp(32'(remote.got_q.size()), 32'h2);
      while (remote.got_q.size() > 0 && exp_q.size() > 0)
        cmp_f(remote.got_q.pop_front(), exp_q.pop_front());
      if (i % 2) begin
        ack <= 1'b1;
        @(posedge pclk);
        ack <= 1'b0;
      end else begin
        apb(OFF_STATUS, 1'b1, 32'h4, r, e);
      end
      apb(OFF_STATUS, 1'b0, 32'h0, r, e);
      cmp(r & 32'h4, 32'h0);
      f = frame(9'(rnd()), int'(nb), 1'b1, opt_t[i][1]);
      @(posedge pclk);
      remote.send(f[8:0], f[9]);
      poll(ST_RXC, 1'b1, 50);
      apb(OFF_CTRL, 1'b0, 32'h0, r, e);
      cmp({31'h0, r[CT_RXB8]}, {31'h0, f[8]});
      apb(OFF_DATA, 1'b0, 32'h0, r, e);
      cmp(r, {24'h0, f[7:0]});
      apb(OFF_STATUS, 1'b0, 32'h0, r, e);
      cmp(r & 32'h1, 32'h0);
    end
    // Synchronous master frame, sampled by the remote at falling clock edges
    apb(OFF_FMT, 1'b1, 32'h143, r, e);
    apb(OFF_CTRL, 1'b1, 32'h1, r, e);
    cmp({31'h0, xck_oe_n}, 32'h0);
    d = rnd();
    apb(OFF_DATA, 1'b1, d, r, e);
    poll(ST_TXC, 1'b1, 50);
    cmp(32'(remote.sync_q.size()), 32'h1);
    if (remote.sync_q.size() > 0)
      cmp_f({2'b0, remote.sync_q.pop_front()}, {3'h1, d[7:0], 1'b0});
    apb(OFF_CTRL, 1'b1, 32'h0, r, e);
    repeat (2) @(posedge pclk);
    cmp({30'h0, xck_oe_n, xck_o}, 32'h2);
    conclude();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    $display("MISMATCH at %0t: run timed out", $time);
    conclude();
  end
endmodule
bind usr_serial_top usr_serial_props props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_in_pin(serial_in_pin), .serial_in_claimed(serial_in_claimed), .serial_out_pin(serial_out_pin),
  .serial_out_oe_n(serial_out_oe_n), .transfer_clock_pin_in(transfer_clock_pin_in),
  .transfer_clock_pin_out(transfer_clock_pin_out), .transfer_clock_pin_oe_n(transfer_clock_pin_oe_n),
  .tx_buffer_empty_irq(tx_buffer_empty_irq), .tx_complete_irq(tx_complete_irq),
  .tx_complete_irq_ack(tx_complete_irq_ack));
`default_nettype wire
